// File: core/tcc_defs.vh
// register map, field layout and reset values of the timer channel control block
//
// Notes on behaviour
// [RULE1] each of three channels owns its count control register; channels behave alike except channel 2 per RULE8 and RULE15.
// [RULE2] clear field bits 6:5: 00 never, 01 event A, 10 event B, 11 synchronized.
// [RULE3] clearing event is compare match in compare mode, capture in capture mode.
// [RULE4] edge field bits 4:3: 00 rising, 01 falling, 1x both edges of external clock.
// [RULE5] clock source 0xx prescaled internal, 010 is clock/4; 100..111 external A..D.
// [RULE6] ratios for internal codes 000, 001, 011 are parameters, rising monotonically.
// [RULE7] internal source counts prescaled falling edges; external counts the chosen edges.
// [RULE8] channel 2 in phase counting mode ignores source and edge fields.
// [RULE9] count control register resets to 80h on reset and on standby entry.
// [RULE10] count control bit 7 and capture/compare bits 7, 3 read one, unwritable.
// [RULE11] capture/compare control register resets to 88h on reset and standby entry.
// [RULE12] field B bits 6:4, 0xx compare: none, drive 0, drive 1, toggle.
// [RULE13] field B 100, 101, 110 capture on rising, falling, both edges; 111 nothing.
// [RULE14] field A bits 2:0 uses the same encoding for general register A.
// [RULE15] channel 2 never toggles; toggle code acts as drive 1.
// [RULE16] compare pin shows output level setting until its first compare match.
// [RULE17] pulse width mode ignores capture/compare settings; both registers compare.
// [RULE18] capture stores counter and sets flag together; compare match sets flag.
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// register byte addresses
`define TCC_OFS_CNT_CTRL0   6'h00
`define TCC_OFS_CNT_CTRL1   6'h04
`define TCC_OFS_CNT_CTRL2   6'h08
`define TCC_OFS_CC_CTRL0    6'h0C
`define TCC_OFS_CC_CTRL1    6'h10
`define TCC_OFS_CC_CTRL2    6'h14
`define TCC_OFS_STATUS      6'h18
`define TCC_OFS_MASK        6'h1C
`define TCC_OFS_STATE       6'h20

// reset values and fixed-one bits
`define TCC_CNT_CTRL_RST    8'h80
`define TCC_CC_CTRL_RST     8'h88
`define TCC_CNT_CTRL_ONES   8'h80
`define TCC_CC_CTRL_ONES    8'h88

// count control fields
`define TCC_CLR_MSB         6
`define TCC_CLR_LSB         5
`define TCC_EDGE_MSB        4
`define TCC_EDGE_LSB        3
`define TCC_SRC_MSB         2
`define TCC_SRC_LSB         0

// capture/compare control fields
`define TCC_FNB_MSB         6
`define TCC_FNB_LSB         4
`define TCC_FNA_MSB         2
`define TCC_FNA_LSB         0

// prescaler ratios
`define TCC_DIV_0           8'h01
`define TCC_DIV_1           8'h02
`define TCC_DIV_2           8'h04
`define TCC_DIV_3           8'h08

// bus responses
`define TCC_RESP_OKAY       2'b00
`define TCC_RESP_SLVERR     2'b10

`endif

// File: core/tcc_chan.v
// one timer channel: counting tick, clear source, compare outputs and capture
`timescale 1ns/1ps
`include "tcc_defs.vh"

module tcc_chan #(
	parameter       IS_CHAN2 = 0,
	parameter [7:0] DIV_0    = `TCC_DIV_0,
	parameter [7:0] DIV_1    = `TCC_DIV_1,
	parameter [7:0] DIV_3    = `TCC_DIV_3
) (
	// clock and reset (reset also covers standby)
	input  wire       clk_in,
	input  wire       rst_in,
	// settings
	input  wire [7:0] cnt_ctrl_in,
	input  wire [7:0] cc_ctrl_in,
	input  wire       phase_mode_in,
	input  wire       pwm_mode_in,
	input  wire [1:0] level_in,
	// events from the counter logic
	input  wire       sync_clear_in,
	input  wire [1:0] match_in,
	// synchronised pins, current and previous
	input  wire [3:0] ext_now_in,
	input  wire [3:0] ext_prev_in,
	input  wire [1:0] pin_now_in,
	input  wire [1:0] pin_prev_in,
	// strobes and pins
	output reg        tick_out,
	output reg        clear_out,
	output reg  [1:0] capture_out,
	output reg  [1:0] flag_out,
	output reg  [1:0] pin_out,
	output reg  [1:0] pin_oe_n_out
);

	wire [1:0] clr_sel  = cnt_ctrl_in[`TCC_CLR_MSB:`TCC_CLR_LSB];
	wire [1:0] edge_sel = cnt_ctrl_in[`TCC_EDGE_MSB:`TCC_EDGE_LSB];
	wire [2:0] src_sel  = cnt_ctrl_in[`TCC_SRC_MSB:`TCC_SRC_LSB];
	wire [2:0] fn_a     = cc_ctrl_in[`TCC_FNA_MSB:`TCC_FNA_LSB];
	wire [2:0] fn_b     = cc_ctrl_in[`TCC_FNB_MSB:`TCC_FNB_LSB];

	reg  [7:0] div_q;
	reg  [7:0] ratio;
	reg  [1:0] started_q;

	// [RULE6] configurable internal ratios
	always @* begin
		case (src_sel[1:0])
			2'b00:   ratio = DIV_0;
			2'b01:   ratio = DIV_1;
			2'b10:   ratio = `TCC_DIV_2;
			default: ratio = DIV_3;
		endcase
	end

	// [RULE7] falling edge of prescaled clock
	wire div_wrap = (div_q >= ratio - 8'h01);

	always @(posedge clk_in) begin
		if (rst_in || div_wrap)
			div_q <= 8'h00;
		else
			div_q <= div_q + 8'h01;
	end

	// [RULE4] external edge choice
	wire ext_now  = ext_now_in[src_sel[1:0]];
	wire ext_prev = ext_prev_in[src_sel[1:0]];
	wire ext_rise = ext_now & ~ext_prev;
	wire ext_fall = ~ext_now & ext_prev;
	wire ext_edge = edge_sel[1] ? (ext_rise | ext_fall) : (edge_sel[0] ? ext_fall : ext_rise);

	// [RULE8] phase counting overrides source
	wire phase_on = (IS_CHAN2 != 0) && phase_mode_in;
	// [RULE5] source select
	wire tick_d   = phase_on ? 1'b0 : (src_sel[2] ? ext_edge : div_wrap);

	function cap_edge;
		input [2:0] fn;
		input       now;
		input       prev;
		begin
			case (fn)
				3'b100:  cap_edge = now & ~prev;
				3'b101:  cap_edge = ~now & prev;
				3'b110:  cap_edge = now ^ prev;
				default: cap_edge = 1'b0;
			endcase
		end
	endfunction

	// drive level after a match in compare mode
	function act_level;
		input [2:0] fn;
		input       cur;
		begin
			case (fn[1:0])
				2'b01:   act_level = 1'b0;
				2'b10:   act_level = 1'b1;
				2'b11:   act_level = (IS_CHAN2 != 0) ? 1'b1 : ~cur;
				default: act_level = cur;
			endcase
		end
	endfunction

	// [RULE17] pulse width mode forces compare
	wire       cap_mode_a = fn_a[2] & ~pwm_mode_in;
	wire       cap_mode_b = fn_b[2] & ~pwm_mode_in;
	// [RULE13] capture edges
	wire [1:0] cap_d = {cap_mode_b & cap_edge(fn_b, pin_now_in[1], pin_prev_in[1]),
	                    cap_mode_a & cap_edge(fn_a, pin_now_in[0], pin_prev_in[0])};
	wire [1:0] cmp_d = {~cap_mode_b & match_in[1], ~cap_mode_a & match_in[0]};
	// [RULE3] event per register
	wire [1:0] event_d = cap_d | cmp_d;

	reg clear_d;
	always @* begin
		// [RULE2] clear select
		case (clr_sel)
			2'b01:   clear_d = event_d[0];
			2'b10:   clear_d = event_d[1];
			2'b11:   clear_d = sync_clear_in;
			default: clear_d = 1'b0;
		endcase
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			tick_out     <= 1'b0;
			clear_out    <= 1'b0;
			capture_out  <= 2'b00;
			flag_out     <= 2'b00;
			pin_out      <= 2'b00;
			pin_oe_n_out <= 2'b11;
			started_q    <= 2'b00;
		end else begin
			tick_out    <= tick_d;
			clear_out   <= clear_d;
			// [RULE18] capture and flag together
			capture_out <= cap_d;
			flag_out    <= event_d;
			started_q   <= started_q | cmp_d;
			// [RULE16] level setting until first match
			// [RULE12] compare pin action, B
			if (cmp_d[1])
				pin_out[1] <= act_level(fn_b, started_q[1] ? pin_out[1] : level_in[1]);
			else if (!started_q[1])
				pin_out[1] <= level_in[1];
			// [RULE14] compare pin action, A
			// [RULE15] channel 2 toggle becomes drive 1
			if (cmp_d[0])
				pin_out[0] <= act_level(fn_a, started_q[0] ? pin_out[0] : level_in[0]);
			else if (!started_q[0])
				pin_out[0] <= level_in[0];
			pin_oe_n_out[1] <= cap_mode_b | (fn_b == 3'b000 && !pwm_mode_in);
			pin_oe_n_out[0] <= cap_mode_a | (fn_a == 3'b000 && !pwm_mode_in);
		end
	end

endmodule

// File: core/tcc_top.v
// timer channel control block: register slave, pin synchronisers and three channels
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tcc_defs.vh"

module tcc_top #(
	parameter [7:0] DIV_0 = `TCC_DIV_0,
	parameter [7:0] DIV_1 = `TCC_DIV_1,
	parameter [7:0] DIV_3 = `TCC_DIV_3
) (
	// clock, reset, standby
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        standby_in,
	// axi4-lite write address
	input  wire [5:0]  s_axi_awaddr_in,
	input  wire [2:0]  s_axi_awprot_in,
	input  wire        s_axi_awvalid_in,
	output reg         s_axi_awready_out,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata_in,
	input  wire [3:0]  s_axi_wstrb_in,
	input  wire        s_axi_wvalid_in,
	output reg         s_axi_wready_out,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp_out,
	output reg         s_axi_bvalid_out,
	input  wire        s_axi_bready_in,
	// axi4-lite read address
	input  wire [5:0]  s_axi_araddr_in,
	input  wire [2:0]  s_axi_arprot_in,
	input  wire        s_axi_arvalid_in,
	output reg         s_axi_arready_out,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata_out,
	output reg  [1:0]  s_axi_rresp_out,
	output reg         s_axi_rvalid_out,
	input  wire        s_axi_rready_in,
	// mode and level settings from neighbouring timer logic
	input  wire        phase_count_mode_flag_in,
	input  wire [2:0]  pwm_mode_in,
	input  wire [5:0]  output_level_in,
	// counter-side events per channel
	input  wire [2:0]  sync_clear_in,
	input  wire [2:0]  match_a_in,
	input  wire [2:0]  match_b_in,
	// external clock pins
	input  wire        ext_clock_in_a,
	input  wire        ext_clock_in_b,
	input  wire        ext_clock_in_c,
	input  wire        ext_clock_in_d,
	// compare/capture pins, A
	input  wire [2:0]  tio_a_in,
	output wire [2:0]  tio_a_out,
	output wire [2:0]  tio_a_oe_n_out,
	// compare/capture pins, B
	input  wire [2:0]  tio_b_in,
	output wire [2:0]  tio_b_out,
	output wire [2:0]  tio_b_oe_n_out,
	// strobes to counter logic
	output wire [2:0]  count_tick_out,
	output wire [2:0]  counter_clear_out,
	output wire [2:0]  capture_a_out,
	output wire [2:0]  capture_b_out,
	// interrupt
	output reg         irq_out
);

	wire        hold_rst = rst_in | standby_in;

	// pin synchronisers: {tio_b, tio_a, ext d..a}
	reg  [9:0]  sync1_q;
	reg  [9:0]  sync2_q;
	reg  [9:0]  prev_q;
	wire [9:0]  pins_raw = {tio_b_in, tio_a_in,
	                        ext_clock_in_d, ext_clock_in_c, ext_clock_in_b, ext_clock_in_a};

	always @(posedge clk_in) begin
		if (rst_in) begin
			sync1_q <= 10'h000;
			sync2_q <= 10'h000;
			prev_q  <= 10'h000;
		end else begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	// control registers, stored bits only
	reg  [7:0]  cnt_ctrl_q [0:2];
	reg  [7:0]  cc_ctrl_q  [0:2];
	reg  [5:0]  status_q;
	reg  [5:0]  mask_q;

	// channel outputs
	wire [2:0]  flag_a;
	wire [2:0]  flag_b;

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : chan
			wire [1:0] cap;
			wire [1:0] flg;
			wire [1:0] pin;
			wire [1:0] oe_n;

			// [RULE1] one channel per register set
			tcc_chan #(
				.IS_CHAN2 (g == 2),
				.DIV_0    (DIV_0),
				.DIV_1    (DIV_1),
				.DIV_3    (DIV_3)
			) u_chan (
				.clk_in        (clk_in),
				.rst_in        (hold_rst),
				.cnt_ctrl_in   (cnt_ctrl_q[g]),
				.cc_ctrl_in    (cc_ctrl_q[g]),
				.phase_mode_in (phase_count_mode_flag_in),
				.pwm_mode_in   (pwm_mode_in[g]),
				.level_in      ({output_level_in[2*g+1], output_level_in[2*g]}),
				.sync_clear_in (sync_clear_in[g]),
				.match_in      ({match_b_in[g], match_a_in[g]}),
				.ext_now_in    (sync2_q[3:0]),
				.ext_prev_in   (prev_q[3:0]),
				.pin_now_in    ({sync2_q[7+g], sync2_q[4+g]}),
				.pin_prev_in   ({prev_q[7+g], prev_q[4+g]}),
				.tick_out      (count_tick_out[g]),
				.clear_out     (counter_clear_out[g]),
				.capture_out   (cap),
				.flag_out      (flg),
				.pin_out       (pin),
				.pin_oe_n_out  (oe_n)
			);

			assign capture_a_out[g]  = cap[0];
			assign capture_b_out[g]  = cap[1];
			assign flag_a[g]         = flg[0];
			assign flag_b[g]         = flg[1];
			assign tio_a_out[g]      = pin[0];
			assign tio_b_out[g]      = pin[1];
			assign tio_a_oe_n_out[g] = oe_n[0];
			assign tio_b_oe_n_out[g] = oe_n[1];
		end
	endgenerate

	// write channel: address and data taken in either order
	reg         aw_got_q;
	reg         w_got_q;
	reg  [5:0]  waddr_q;
	reg  [7:0]  wbyte_q;
	reg         wlane_q;

	wire        aw_take  = s_axi_awvalid_in & s_axi_awready_out;
	wire        w_take   = s_axi_wvalid_in & s_axi_wready_out;
	wire        wr_fire  = aw_got_q & w_got_q & ~s_axi_bvalid_out;
	wire        wr_ok    = (waddr_q <= `TCC_OFS_MASK) && (waddr_q[1:0] == 2'b00);
	wire        wr_en    = wr_fire & wr_ok & wlane_q;
	wire        b_done   = s_axi_bvalid_out & s_axi_bready_in;

	always @(posedge clk_in) begin
		if (rst_in) begin
			aw_got_q          <= 1'b0;
			w_got_q           <= 1'b0;
			waddr_q           <= 6'h00;
			wbyte_q           <= 8'h00;
			wlane_q           <= 1'b0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out  <= 1'b1;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= `TCC_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_got_q          <= 1'b1;
				waddr_q           <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (w_take) begin
				w_got_q          <= 1'b1;
				wbyte_q          <= s_axi_wdata_in[7:0];
				wlane_q          <= s_axi_wstrb_in[0];
				s_axi_wready_out <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= wr_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
			end
			if (b_done) begin
				s_axi_bvalid_out  <= 1'b0;
				aw_got_q          <= 1'b0;
				w_got_q           <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out  <= 1'b1;
			end
		end
	end

	// control register writes
	integer i;
	always @(posedge clk_in) begin
		if (hold_rst) begin
			for (i = 0; i < 3; i = i + 1) begin
				// [RULE9] count control reset value
				cnt_ctrl_q[i] <= `TCC_CNT_CTRL_RST;
				// [RULE11] capture/compare reset value
				cc_ctrl_q[i]  <= `TCC_CC_CTRL_RST;
			end
			mask_q <= 6'h00;
		end else if (wr_en) begin
			for (i = 0; i < 3; i = i + 1) begin
				// [RULE10] fixed-one bits kept
				if (waddr_q == `TCC_OFS_CNT_CTRL0 + 6'h04 * i[5:0])
					cnt_ctrl_q[i] <= wbyte_q | `TCC_CNT_CTRL_ONES;
				if (waddr_q == `TCC_OFS_CC_CTRL0 + 6'h04 * i[5:0])
					cc_ctrl_q[i] <= wbyte_q | `TCC_CC_CTRL_ONES;
			end
			if (waddr_q == `TCC_OFS_MASK)
				mask_q <= wbyte_q[5:0];
		end
	end

	// sticky event status, write one to clear, set wins
	wire [5:0]  status_set = {flag_b, flag_a};
	wire [5:0]  status_clr = (wr_en && waddr_q == `TCC_OFS_STATUS) ? wbyte_q[5:0] : 6'h00;
	wire [5:0]  status_d   = (status_q & ~status_clr) | status_set;

	always @(posedge clk_in) begin
		if (hold_rst) begin
			status_q <= 6'h00;
			irq_out  <= 1'b0;
		end else begin
			// [RULE18] match or capture flags
			status_q <= status_d;
			irq_out  <= |(status_d & mask_q);
		end
	end

	// read channel
	reg  [7:0]  rd_byte;
	reg         rd_ok;
	wire        ar_take = s_axi_arvalid_in & s_axi_arready_out;
	wire        r_done  = s_axi_rvalid_out & s_axi_rready_in;

	always @* begin
		rd_ok = (s_axi_araddr_in[1:0] == 2'b00);
		case (s_axi_araddr_in)
			`TCC_OFS_CNT_CTRL0: rd_byte = cnt_ctrl_q[0];
			`TCC_OFS_CNT_CTRL1: rd_byte = cnt_ctrl_q[1];
			`TCC_OFS_CNT_CTRL2: rd_byte = cnt_ctrl_q[2];
			`TCC_OFS_CC_CTRL0:  rd_byte = cc_ctrl_q[0];
			`TCC_OFS_CC_CTRL1:  rd_byte = cc_ctrl_q[1];
			`TCC_OFS_CC_CTRL2:  rd_byte = cc_ctrl_q[2];
			`TCC_OFS_STATUS:    rd_byte = {2'b00, status_q};
			`TCC_OFS_MASK:      rd_byte = {2'b00, mask_q};
			`TCC_OFS_STATE:     rd_byte = {2'b00, tio_b_out, tio_a_out};
			default: begin
				rd_byte = 8'h00;
				rd_ok   = 1'b0;
			end
		endcase
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0000_0000;
			s_axi_rresp_out   <= `TCC_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rdata_out   <= {24'h00_0000, rd_byte};
			s_axi_rresp_out   <= rd_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
		end else if (r_done) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out  <= 1'b0;
		end
	end

endmodule

// File: bench/tcc_top_properties.sv
// port-level checks for the timer channel control block
`timescale 1ns/1ps
module tcc_top_properties (
	// clock, reset, standby
	input wire logic       clk_in, rst_in, standby_in,
	// bus read handshake
	input wire logic       s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out,
	// settings and events
	input wire logic       phase_count_mode_flag_in,
	input wire logic [2:0] pwm_mode_in, sync_clear_in, match_a_in, match_b_in,
	// pins
	input wire logic [2:0] tio_a_in, tio_b_in, tio_a_oe_n_out, tio_b_oe_n_out,
	// strobes and interrupt
	input wire logic [2:0] count_tick_out, counter_clear_out, capture_a_out, capture_b_out,
	input wire logic       irq_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	clear_cause_a: assert property (counter_clear_out[0] |->
		$past(match_a_in[0]) || $past(match_b_in[0]) || $past(sync_clear_in[0])
		|| capture_a_out[0] || capture_b_out[0]) else $error("clear without a cause");
	phase_no_tick_a: assert property (phase_count_mode_flag_in && $past(phase_count_mode_flag_in)
		|-> !count_tick_out[2]) else $error("tick in phase mode");
	cap_a_edge_a: assert property (capture_a_out[0]
		|-> $past(tio_a_in[0], 3) != $past(tio_a_in[0], 4)) else $error("capture a without edge");
	cap_b_edge_a: assert property (capture_b_out[0]
		|-> $past(tio_b_in[0], 3) != $past(tio_b_in[0], 4)) else $error("capture b without edge");
	reset_pins_a: assert property ($past(rst_in)
		|-> &tio_a_oe_n_out && &tio_b_oe_n_out && !irq_out) else $error("pins not idle after reset");
	standby_idle_a: assert property ($past(standby_in)
		|-> &tio_a_oe_n_out && count_tick_out == 3'b000) else $error("standby left channel busy");
	pwm_nocap_a: assert property (pwm_mode_in[1] && $past(pwm_mode_in[1])
		|-> !capture_a_out[1] && !capture_b_out[1]) else $error("capture in pwm");
	pwm_drive_a: assert property (pwm_mode_in[1] && $past(pwm_mode_in[1]) && !$past(rst_in)
		&& !$past(standby_in) |-> !tio_a_oe_n_out[1]) else $error("pwm pin not driven");
	read_latency_a: assert property (s_axi_arvalid_in && s_axi_arready_out
		|=> s_axi_rvalid_out) else $error("read answer late");
endmodule

bind tcc_top tcc_top_properties u_chk (.clk_in, .rst_in, .standby_in, .s_axi_arvalid_in,
	.s_axi_arready_out, .s_axi_rvalid_out, .phase_count_mode_flag_in, .pwm_mode_in, .sync_clear_in,
	.match_a_in, .match_b_in, .tio_a_in, .tio_b_in, .tio_a_oe_n_out, .tio_b_oe_n_out,
	.count_tick_out, .counter_clear_out, .capture_a_out, .capture_b_out, .irq_out);

// File: bench/tcc_far.sv
// far-side model: external clock pins and capture pins, idle low
`timescale 1ns/1ps
module tcc_far (
	// external clock pins
	output logic [3:0] ext_out,
	// capture pins
	output logic [2:0] cap_a_out,
	output logic [2:0] cap_b_out
);
	initial begin
		ext_out = 4'h0;
		cap_a_out = 3'b000;
		cap_b_out = 3'b000;
	end
	// n pulses on clock pin j, half period h ns
	task automatic burst(input int j, input int n, input int h);
		repeat (n) begin
			#h ext_out[j] = 1'b1;
			#h ext_out[j] = 1'b0;
		end
	endtask
	// n pulses on both capture pins of channel c
	task automatic cap(input int c, input int n, input int h);
		repeat (n) begin
			#h {cap_a_out[c], cap_b_out[c]} = 2'b11;
			#h {cap_a_out[c], cap_b_out[c]} = 2'b00;
		end
	endtask
endmodule

// File: bench/tcc_top_tb.sv
// self-checking bench for the timer channel control block
`timescale 1ns/1ps
module tcc_top_tb;
	logic        clk_in, rst_in, standby_in, phase_count_mode_flag_in, irq_out;
	logic        s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
	logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic [5:0]  s_axi_awaddr_in, s_axi_araddr_in, output_level_in;
	logic [2:0]  s_axi_awprot_in, s_axi_arprot_in, pwm_mode_in, sync_clear_in, match_a_in, match_b_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
	logic [3:0]  s_axi_wstrb_in, ext;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
	logic [2:0]  tio_a_in, tio_b_in, tio_a_out, tio_b_out, tio_a_oe_n_out, tio_b_oe_n_out;
	logic [2:0]  count_tick_out, counter_clear_out, capture_a_out, capture_b_out;
	logic [33:0] q_r[$];
	logic [1:0]  q_b[$];
	int          err_total = 0;
	int          checked = 0;
	int          nt, nc, na, nb, n1;

	tcc_top u_dut (.clk_in, .rst_in, .standby_in,
		.s_axi_awaddr_in, .s_axi_awprot_in, .s_axi_awvalid_in, .s_axi_awready_out,
		.s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
		.s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
		.s_axi_araddr_in, .s_axi_arprot_in, .s_axi_arvalid_in, .s_axi_arready_out,
		.s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
		.phase_count_mode_flag_in, .pwm_mode_in, .output_level_in, .sync_clear_in, .match_a_in, .match_b_in,
		.ext_clock_in_a(ext[0]), .ext_clock_in_b(ext[1]), .ext_clock_in_c(ext[2]), .ext_clock_in_d(ext[3]),
		.tio_a_in, .tio_a_out, .tio_a_oe_n_out, .tio_b_in, .tio_b_out, .tio_b_oe_n_out,
		.count_tick_out, .counter_clear_out, .capture_a_out, .capture_b_out, .irq_out);
	tcc_far u_far (.ext_out(ext), .cap_a_out(tio_a_in), .cap_b_out(tio_b_in));

	task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("mismatches %0d of %0d checks", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic tmo(input bit got);
		if (!got) begin
			err_total++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r);
		bit got;
		got = 0;
		q_b.push_back(r);
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= {24'h00_0000, d};
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'b111;
		repeat (40) if (!got) begin
			@(posedge clk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
			got = s_axi_bvalid_out;
		end
		s_axi_bready_in <= 1'b0;
		tmo(got);
	endtask
	task automatic rd(input logic [5:0] a, input logic [33:0] e);
		bit got;
		got = 0;
		q_r.push_back(e);
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		{s_axi_arvalid_in, s_axi_rready_in} <= 2'b11;
		repeat (40) if (!got) begin
			@(posedge clk_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
			got = s_axi_rvalid_out;
		end
		s_axi_rready_in <= 1'b0;
		tmo(got);
	endtask
	// counts strobes of one channel, plus captures of channel 1
	task automatic watch(input int ch, input int n);
		{nt, nc, na, nb, n1} = '0;
		repeat (n) begin
			@(posedge clk_in);
			nt += count_tick_out[ch] === 1'b1;
			nc += counter_clear_out[ch] === 1'b1;
			na += capture_a_out[ch] === 1'b1;
			nb += capture_b_out[ch] === 1'b1;
			n1 += (capture_a_out[1] | capture_b_out[1]) !== 1'b0;
		end
	endtask
	task automatic ev(input logic [2:0] a, input logic [2:0] b, input logic [2:0] s);
		@(posedge clk_in);
		{match_a_in, match_b_in, sync_clear_in} <= {a, b, s};
		@(posedge clk_in);
		{match_a_in, match_b_in, sync_clear_in} <= 9'h000;
		@(posedge clk_in);
	endtask

	// bus answers against the oldest note
	always @(posedge clk_in) begin
		if (s_axi_rvalid_out && s_axi_rready_in)
			chk("rdata", {s_axi_rresp_out, s_axi_rdata_out}, q_r.pop_front());
		if (s_axi_bvalid_out && s_axi_bready_in)
			chk("bresp", {32'h0000_0000, s_axi_bresp_out}, {32'h0000_0000, q_b.pop_front()});
	end

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	initial begin
		int i, j, e;
		logic [7:0] d;
		{rst_in, standby_in, phase_count_mode_flag_in} = 3'b100;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 5'h00;
		{s_axi_awaddr_in, s_axi_araddr_in, output_level_in} = 18'h0_0000;
		{s_axi_awprot_in, s_axi_arprot_in, pwm_mode_in} = 9'h000;
		{sync_clear_in, match_a_in, match_b_in} = 9'h000;
		s_axi_wdata_in = 32'h0000_0000;
		s_axi_wstrb_in = 4'hF;
		void'($urandom(32'h99c5_2884));
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		for (i = 0; i < 6; i++)
			rd(6'(i * 4), {26'h000_0000, i < 3 ? 8'h80 : 8'h88});
		for (i = 0; i < 6; i++) begin
			d = 8'($urandom);
			wr(6'(i * 4), d, 2'b00);
			rd(6'(i * 4), {26'h000_0000, d | (i < 3 ? 8'h80 : 8'h88)});
		end
		wr(6'h20, 8'hFF, 2'b10);
		wr(6'h02, 8'hFF, 2'b10);
		rd(6'h24, {2'b10, 32'h0000_0000});
		for (i = 0; i < 4; i++) begin
			wr(6'h00, 8'(i), 2'b00);
			watch(0, 8);
			watch(0, 64);
			chk("int ticks", 34'(nt), 34'(64 >> i));
		end
		for (i = 0; i < 4; i++) begin
			wr(6'h00, 8'(i * 9 + 4), 2'b00);
			fork
				u_far.burst(0, 2, 113);
				u_far.burst(1, 3, 101);
				u_far.burst(2, 4, 89);
				u_far.burst(3, 5, 77);
				watch(0, 60);
			join
			chk("ext ticks", 34'(nt), 34'(i < 2 ? i + 2 : 2 * i + 4));
		end
		for (j = 0; j < 3; j++) begin
			wr(6'(12 + j * 4), 8'h00, 2'b00);
			for (i = 0; i < 4; i++) begin
				wr(6'(j * 4), 8'(i * 32 + 2), 2'b00);
				ev(3'(1 << j), 3'b000, 3'b000);
				chk("clr a", counter_clear_out[j], i == 1);
				ev(3'b000, 3'(1 << j), 3'b000);
				chk("clr b", counter_clear_out[j], i == 2);
				ev(3'b000, 3'b000, 3'(1 << j));
				chk("clr sync", counter_clear_out[j], i == 3);
			end
		end
		wr(6'h08, 8'h02, 2'b00);
		phase_count_mode_flag_in <= 1'b1;
		watch(2, 8);
		watch(2, 40);
		chk("phase ticks", 34'(nt), 34'h0);
		phase_count_mode_flag_in <= 1'b0;
		watch(2, 8);
		watch(2, 40);
		chk("ch2 ticks", 34'(nt), 34'hA);
		wr(6'h00, 8'h7F, 2'b00);
		output_level_in <= 6'h11;
		standby_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		standby_in <= 1'b0;
		rd(6'h00, 34'h80);
		rd(6'h0C, 34'h88);
		for (j = 0; j < 3; j += 2) begin
			wr(6'(12 + j * 4), 8'h11, 2'b00);
			repeat (2) @(posedge clk_in);
			chk("level", {tio_b_out[j], tio_a_out[j]}, 2'b01);
			chk("drive", {tio_b_oe_n_out[j], tio_a_oe_n_out[j]}, 2'b00);
			for (i = 1; i < 5; i++) begin
				wr(6'(12 + j * 4), 8'(i < 4 ? i * 17 : 51), 2'b00);
				ev(3'(1 << j), 3'(1 << j), 3'b000);
				e = i == 2 || i == 4 || (i == 3 && j == 2) ? 3 : 0;
				chk("pin", {tio_b_out[j], tio_a_out[j]}, 34'(e));
			end
		end
		wr(6'h18, 8'h3F, 2'b00);
		wr(6'h00, 8'h22, 2'b00);
		pwm_mode_in <= 3'b010;
		wr(6'h10, 8'hEE, 2'b00);
		for (i = 4; i < 8; i++) begin
			wr(6'h0C, 8'(i * 17), 2'b00);
			fork
				u_far.cap(0, 2, 97);
				u_far.cap(1, 2, 97);
				watch(0, 40);
			join
			e = i == 6 ? 4 : i == 7 ? 0 : 2;
			chk("cap a", 34'(na), 34'(e));
			chk("cap b", 34'(nb), 34'(e));
			chk("cap clr", 34'(nc), 34'(e));
			chk("pwm cap", 34'(n1), 34'h0);
		end
		chk("pwm oe", tio_a_oe_n_out[1], 1'b0);
		rd(6'h18, 34'h09);
		chk("irq masked", irq_out, 1'b0);
		wr(6'h1C, 8'h01, 2'b00);
		repeat (2) @(posedge clk_in);
		chk("irq set", irq_out, 1'b1);
		wr(6'h18, 8'h01, 2'b00);
		repeat (2) @(posedge clk_in);
		chk("irq clr", irq_out, 1'b0);
		rd(6'h18, 34'h08);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(6'h04, 34'h80);
		end_of_test();
	end
endmodule
